// ### hdl/tkc_defs.vh
// Constants for the touch key slot counter control block.
// Assumes inclusion by bare name from the block's design file.
`ifndef TKC_DEFS_VH
`define TKC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define TKC_OFF_SLOT_PRELOAD 8'h00
`define TKC_OFF_CTRL0 8'h04
`define TKC_OFF_CTRL1 8'h08
`define TKC_OFF_FCNT_LO 8'h0c
`define TKC_OFF_FCNT_HI 8'h10
`define TKC_OFF_CFCNT_LO 8'h14
`define TKC_OFF_CFCNT_HI 8'h18
`define TKC_OFF_REFCAP_LO 8'h1c
`define TKC_OFF_REFCAP_HI 8'h20
`define TKC_OFF_MCTRL0 8'h24
`define TKC_OFF_MCTRL1 8'h28
`define TKC_OFF_IRQ_STATUS 8'h2c
`define TKC_OFF_IRQ_MASK 8'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TKC_C0_SLOTOV 6
`define TKC_C0_START 5
`define TKC_C0_CFOV 4
`define TKC_C0_FOV 3
`define TKC_M1_SLOTSRC 7
`define TKC_M1_REFEN 5
`define TKC_M1_KEYEN 4
`define TKC_M1_K2EN 1
`define TKC_M1_K1EN 0
`define TKC_IRQ_SLOT 0
`define TKC_IRQ_CF 1
`define TKC_IRQ_FUNC 2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define TKC_RST_BYTE 8'h00
`define TKC_RST_CTRL1 2'h3
`define TKC_RST_IRQ 3'h0
`define TKC_UNIT_LAST 5'h1f
`define TKC_SLOT_LAST 8'hff
`define TKC_CNT_LAST 16'hffff
`define TKC_KEYSEL_K1 2'h0
`define TKC_KEYSEL_K2 2'h1
`define TKC_SLOT_DIV_LAST 2'h3

`endif

// ### hdl/tkc_top.v
// Touch key module control: time slot window, C/F and function counters,
// overflow flags, interrupt and APB register access.
// Assumes a synchronous APB master on clk; sense and reference oscillator
// outputs arrive asynchronously and are resynchronised here.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "tkc_defs.vh"

// Functional notes
// - Slot window overflows after (256 - preload) units of 32 slot clocks.
// - A 5-bit unit counter completes one unit every 32 slot clock ticks.
// - Slot overflow sets flag bit 6, interrupt request, stops oscillators.
// - Slot overflow halts C/F, function, unit and slot counters.
// - Software writing one to slot flag never raises interrupt; software clears it.
// - Start bit low holds C/F, function and unit counters cleared.
// - Clearing start leaves the 8-bit slot counter contents unchanged.
// - Start bit rising enables all counters and oscillators, starting detection.
// - C/F counter overflow sets flag bit 4; software clears it.
// - Function counter overflow sets flag bit 3; software clears it.
// - Function clock select codes 0..3 pick system clock divided 1, 2, 4, 8.
// - Bits 7 and 2 of control register 0 read as zero.
// - Two touch inputs, each with own sense oscillator, plus control registers.
// - Slot clock source: reference oscillator when zero, system clock/4 when one.
// - Function counter freezes at slot overflow and keeps its value.
// - Key select 00 routes key 1, 01 key 2 to C/F counter; others count nothing.
module tkc_top #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire touch_input_1,
  input wire touch_input_2,
  input wire ref_osc_in,
  output wire key_osc_en,
  output wire ref_osc_en,
  output wire touch_input_1_en,
  output wire touch_input_2_en,
  output wire detect_busy,
  output wire [1:0] osc_freq_select,
  output wire [9:0] ref_cap_value,
  output wire [7:0] osc_config,
  output wire touch_irq_request,
  output wire irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [7:0] preload_ff;
  reg start_ff;
  reg slotov_ff;
  reg cfov_ff;
  reg fov_ff;
  reg [1:0] fsel_ff;
  reg [1:0] freq_ff;
  reg [9:0] refcap_ff;
  reg [7:0] mctrl0_ff;
  reg [4:0] mctrl1_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;
  reg setup_ff;

  // ----------------------------------------------------------------
  // Measurement state
  // ----------------------------------------------------------------
  reg run_ff;
  reg [4:0] unit_ff;
  reg [7:0] slot_ff;
  reg [15:0] cf_ff;
  reg [15:0] fcnt_ff;
  reg [2:0] fdiv_ff;
  reg [1:0] sdiv_ff;

  wire [2:0] async_in;
  wire [2:0] rise;
  wire [7:0] idx;
  wire access;
  wire wr_en;
  wire [7:0] wdat;
  wire wr_ctrl0;
  wire start_rise;
  wire slot_src;
  wire [1:0] key_sel;
  wire sdiv_tick;
  wire slot_tick;
  wire unit_wrap;
  wire slot_ov_ev;
  reg ftick;
  reg cf_tick;
  wire cf_ov_ev;
  wire f_ov_ev;
  reg [7:0] rd_byte;
  reg rd_hit;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Oscillators are unrelated to clk, so each takes two flops before use;
  // the third flop only serves edge detection. Edges faster than clk/2 are
  // lost, which bounds the usable oscillator rate.
  assign async_in = {ref_osc_in, touch_input_2, touch_input_1};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg meta_ff;
      reg sync_ff;
      reg prev_ff;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          prev_ff <= 1'b0;
        end else if (ce) begin
          meta_ff <= async_in[gi];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      assign rise[gi] = sync_ff & ~prev_ff;
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  // One wait-free access phase after a setup seen with ce high; read data
  // is captured at setup so prdata comes straight from a flop.
  // Address bits above the byte map must be zero; otherwise the access
  // lands on an unaligned index and is refused with pslverr.
  generate
    if (ADDR_W > 8) begin : g_idx_wide
      assign idx = (|paddr[ADDR_W-1:8]) ? 8'hff : paddr[7:0];
    end else if (ADDR_W == 8) begin : g_idx_exact
      assign idx = paddr;
    end else begin : g_idx_narrow
      assign idx = {{(8 - ADDR_W){1'b0}}, paddr};
    end
  endgenerate
  assign access = psel & penable;
  assign pready = access & setup_ff & ce;
  assign wr_en = pready & pwrite & ~pslverr;
  assign wdat = pwdata[7:0];
  assign wr_ctrl0 = wr_en & (idx == `TKC_OFF_CTRL0);
  assign start_rise = wr_ctrl0 & wdat[`TKC_C0_START] & ~start_ff;

  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (idx)
      `TKC_OFF_SLOT_PRELOAD: rd_byte = preload_ff;
      `TKC_OFF_CTRL0: begin
        rd_byte = {1'b0, slotov_ff, start_ff, cfov_ff, fov_ff, 1'b0, fsel_ff};
      end
      `TKC_OFF_CTRL1: rd_byte = {6'h00, freq_ff};
      `TKC_OFF_FCNT_LO: rd_byte = fcnt_ff[7:0];
      `TKC_OFF_FCNT_HI: rd_byte = fcnt_ff[15:8];
      `TKC_OFF_CFCNT_LO: rd_byte = cf_ff[7:0];
      `TKC_OFF_CFCNT_HI: rd_byte = cf_ff[15:8];
      `TKC_OFF_REFCAP_LO: rd_byte = refcap_ff[7:0];
      `TKC_OFF_REFCAP_HI: rd_byte = {6'h00, refcap_ff[9:8]};
      `TKC_OFF_MCTRL0: rd_byte = mctrl0_ff;
      `TKC_OFF_MCTRL1: begin
        rd_byte = {mctrl1_ff[4], 1'b0, mctrl1_ff[3:2], 2'b00, mctrl1_ff[1:0]};
      end
      `TKC_OFF_IRQ_STATUS: rd_byte = {5'h00, irq_stat_ff};
      `TKC_OFF_IRQ_MASK: rd_byte = {5'h00, irq_mask_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setup_ff <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel & ~penable) begin
        setup_ff <= 1'b1;
        prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
        pslverr <= ~rd_hit;
      end else if (pready) begin
        setup_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preload_ff <= `TKC_RST_BYTE;
      start_ff <= 1'b0;
      fsel_ff <= 2'h0;
      freq_ff <= `TKC_RST_CTRL1;
      refcap_ff <= 10'h000;
      mctrl0_ff <= `TKC_RST_BYTE;
      mctrl1_ff <= 5'h00;
      irq_mask_ff <= `TKC_RST_IRQ;
    end else if (ce && wr_en) begin
      case (idx)
        `TKC_OFF_SLOT_PRELOAD: preload_ff <= wdat;
        `TKC_OFF_CTRL0: begin
          start_ff <= wdat[`TKC_C0_START];
          fsel_ff <= wdat[1:0];
        end
        `TKC_OFF_CTRL1: freq_ff <= wdat[1:0];
        `TKC_OFF_REFCAP_LO: refcap_ff[7:0] <= wdat;
        `TKC_OFF_REFCAP_HI: refcap_ff[9:8] <= wdat[1:0];
        `TKC_OFF_MCTRL0: mctrl0_ff <= wdat;
        `TKC_OFF_MCTRL1: mctrl1_ff <= {wdat[7], wdat[5:4], wdat[1:0]};
        `TKC_OFF_IRQ_MASK: irq_mask_ff <= wdat[2:0];
        default: ;
      endcase
    end
  end

  assign slot_src = mctrl1_ff[4];
  assign key_sel = mctrl0_ff[7:6];

  // ----------------------------------------------------------------
  // Overflow flags and interrupt status
  // ----------------------------------------------------------------
  // Hardware set wins over a software write in the same cycle, so an
  // overflow landing on a clear is never lost.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slotov_ff <= 1'b0;
      cfov_ff <= 1'b0;
      fov_ff <= 1'b0;
      irq_stat_ff <= `TKC_RST_IRQ;
    end else if (ce) begin
      if (slot_ov_ev)
        slotov_ff <= 1'b1;
      else if (wr_ctrl0)
        slotov_ff <= wdat[`TKC_C0_SLOTOV];
      if (cf_ov_ev)
        cfov_ff <= 1'b1;
      else if (wr_ctrl0)
        cfov_ff <= wdat[`TKC_C0_CFOV];
      if (f_ov_ev)
        fov_ff <= 1'b1;
      else if (wr_ctrl0)
        fov_ff <= wdat[`TKC_C0_FOV];
      // Only hardware events reach the status; a software set of the slot flag does not
      irq_stat_ff <= (irq_stat_ff & ~((wr_en && idx == `TKC_OFF_IRQ_STATUS) ? wdat[2:0] : 3'h0))
                     | {f_ov_ev, cf_ov_ev, slot_ov_ev};
    end
  end

  // Level interrupt: stays high until software writes one to the status
  // bit; the slot request output follows the slot status bit alone
  assign touch_irq_request = irq_stat_ff[`TKC_IRQ_SLOT];
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------------------------------
  // Detection run control and time slot
  // ----------------------------------------------------------------
  // A restart needs start written 0 first; writing 1 over 1 is ignored
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      run_ff <= 1'b0;
    else if (ce) begin
      if (start_rise)
        run_ff <= 1'b1;
      else if (slot_ov_ev || !start_ff)
        run_ff <= 1'b0;
    end
  end

  // System clock divided by 4 as the alternate slot clock
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      sdiv_ff <= 2'h0;
    else if (ce)
      sdiv_ff <= run_ff ? sdiv_ff + 2'h1 : 2'h0;
  end

  assign sdiv_tick = (sdiv_ff == `TKC_SLOT_DIV_LAST);
  assign slot_tick = run_ff & (slot_src ? sdiv_tick : rise[2]);
  assign unit_wrap = slot_tick & (unit_ff == `TKC_UNIT_LAST);
  assign slot_ov_ev = unit_wrap & (slot_ff == `TKC_SLOT_LAST);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unit_ff <= 5'h00;
      slot_ff <= 8'h00;
    end else if (ce) begin
      if (!start_ff)
        unit_ff <= 5'h00;
      else if (slot_tick)
        unit_ff <= unit_ff + 5'h01;
      // Slot counter keeps its contents while start is low; after overflow it
      // wraps to zero and waits for the next start to copy the preload in
      if (start_rise)
        slot_ff <= preload_ff;
      else if (unit_wrap)
        slot_ff <= slot_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Function and C/F counters
  // ----------------------------------------------------------------
  always @* begin
    case (fsel_ff)
      2'h0: ftick = 1'b1;
      2'h1: ftick = fdiv_ff[0];
      2'h2: ftick = &fdiv_ff[1:0];
      default: ftick = &fdiv_ff;
    endcase
    ftick = ftick & run_ff;
    case (key_sel)
      `TKC_KEYSEL_K1: cf_tick = rise[0];
      `TKC_KEYSEL_K2: cf_tick = rise[1];
      default: cf_tick = 1'b0;
    endcase
    cf_tick = cf_tick & run_ff;
  end

  // The divider restarts with each detection, so the first function tick
  // lands a fixed number of cycles after start
  assign cf_ov_ev = cf_tick & (cf_ff == `TKC_CNT_LAST);
  assign f_ov_ev = ftick & (fcnt_ff == `TKC_CNT_LAST);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fdiv_ff <= 3'h0;
      fcnt_ff <= 16'h0000;
      cf_ff <= 16'h0000;
    end else if (ce) begin
      if (!start_ff) begin
        fdiv_ff <= 3'h0;
        fcnt_ff <= 16'h0000;
        cf_ff <= 16'h0000;
      end else begin
        if (run_ff)
          fdiv_ff <= fdiv_ff + 3'h1;
        if (ftick)
          fcnt_ff <= fcnt_ff + 16'h0001;
        if (cf_tick)
          cf_ff <= cf_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator controls
  // ----------------------------------------------------------------
  // Oscillators run only during a detection cycle, so they stop at overflow
  // Key enables are plain register bits; they only pick which pads are live
  assign key_osc_en = run_ff & mctrl1_ff[2];
  assign ref_osc_en = run_ff & mctrl1_ff[3];
  assign touch_input_1_en = mctrl1_ff[0];
  assign touch_input_2_en = mctrl1_ff[1];
  assign detect_busy = run_ff;
  assign osc_freq_select = freq_ff;
  assign ref_cap_value = refcap_ff;
  assign osc_config = mctrl0_ff;

endmodule

// ### tb/tkc_monitor.sv
// Port checker for the touch key control block.
// Assumes a master that always runs a setup cycle before each access.
`timescale 1ns/100ps
module tkc_monitor #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire key_osc_en,
  input wire ref_osc_en,
  input wire touch_input_1_en,
  input wire touch_input_2_en,
  input wire detect_busy,
  input wire touch_irq_request
);
  // Start bit as last written, so a start is only expected on a 0 to 1 write
  reg start_shadow_ff;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      start_shadow_ff <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 'h04)
      start_shadow_ff <= pwdata[5];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready && pwrite;
  endsequence
  ready_now_a: assert property (psel && penable && ce |-> pready) else $error("no ready in access");
  bad_addr_a: assert property (setup_s ##0 (paddr > 'h30) |=> pslverr) else $error("no error on bad address");
  rsvd_zero_a: assert property (setup_s ##0 (!pwrite && paddr == 'h04) |=> !prdata[7] && !prdata[2])
    else $error("reserved control bits read nonzero");
  key_en_a: assert property (access_s ##0 (paddr == 'h28) |=> touch_input_1_en == $past(pwdata[0]) &&
    touch_input_2_en == $past(pwdata[1])) else $error("key enables not updated");
  start_run_a: assert property (access_s ##0 (paddr == 'h04 && pwdata[5] && !start_shadow_ff)
    |-> ##[1:2] detect_busy) else $error("start did not begin detection");
  osc_stop_a: assert property (!detect_busy |-> !key_osc_en && !ref_osc_en)
    else $error("oscillator enabled while idle");
  slot_end_a: assert property ($rose(touch_irq_request) |-> !detect_busy)
    else $error("request raised while still running");
  req_clear_a: assert property ($fell(touch_irq_request) |-> $past(psel && penable && pwrite))
    else $error("request dropped without a write");
endmodule

// ### tb/touch_key_slot_counter_control_test.sv
// Self-checking bench for the touch key control block.
// Assumes the design answers APB with the register map of its hand-over.
`timescale 1ns/100ps
module touch_key_slot_counter_control_test;
  reg clk, rstn, ce, psel, penable, pwrite, t1, t2, refo, err;
  reg [7:0] paddr, p;
  reg [31:0] pwdata, rd, seed;
  reg [1:0] fs;
  wire pready, pslverr, key_osc_en, ref_osc_en, touch_input_1_en, touch_input_2_en, detect_busy, touch_irq_request, irq;
  wire [31:0] prdata;
  wire [1:0] osc_freq_select;
  wire [9:0] ref_cap_value;
  wire [7:0] osc_config;
  integer cf_q[$];
  integer errors, n_tests, tmo, k, cyc, e1, e2, n1, n2, ex, v, f1;
  tkc_top uut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .touch_input_1(t1), .touch_input_2(t2), .ref_osc_in(refo), .key_osc_en(key_osc_en),
    .ref_osc_en(ref_osc_en), .touch_input_1_en(touch_input_1_en), .touch_input_2_en(touch_input_2_en), .detect_busy(detect_busy),
    .osc_freq_select(osc_freq_select), .ref_cap_value(ref_cap_value), .osc_config(osc_config),
    .touch_irq_request(touch_irq_request), .irq(irq));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One idle cycle after each transfer so psel is never set twice in a step
  task apb(input w, input [7:0] a, input [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task rd16(input [7:0] a);
    apb(0, a, 0);
    v = rd[7:0];
    apb(0, a + 8'h04, 0);
    v = v + rd[7:0] * 256;
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, reset and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tmo = tmo + 1;
    if (tmo == 20000) begin
      errors = errors + 1;
      final_report;
    end
  end
  initial begin
    {rstn, psel, penable, pwrite, t1, t2, refo} = 0;
    ce = 1; paddr = 0; pwdata = 0; errors = 0; n_tests = 0; tmo = 0; seed = 32'h27500cfc;
    repeat (6) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, 8'h00, 0); chk(rd, 0, "preload reset");
    apb(0, 8'h04, 0); chk(rd, 0, "control0 reset");
    apb(0, 8'h08, 0); chk(rd, 3, "control1 reset");
    seed = xs(seed);
    apb(1, 8'h1c, seed[7:0]);
    apb(1, 8'h20, seed[15:8]);
    apb(1, 8'h08, seed[17:16]);
    chk(ref_cap_value, seed[9:0], "ref cap port");
    chk(osc_freq_select, seed[17:16], "freq select port");
    apb(0, 8'h20, 0);
    chk(rd, seed[9:8], "ref cap high");
    apb(0, 8'h08, 0);
    chk(rd, seed[17:16], "control1");
    // Three windows: key 1, key 2, then a reserved selection that counts
    // nothing; the last window also holds ce low for 40 cycles
    for (k = 0; k < 3; k = k + 1) begin
      seed = xs(seed);
      p = 8'hf9 + seed[1:0];
      fs = seed[3:2];
      n1 = 4 + seed[8:4];
      n2 = 4 + seed[13:9];
      cf_q.push_back(k == 0 ? n1 : k == 1 ? n2 : 0);
      apb(1, 8'h04, 0); apb(1, 8'h28, 8'hb3); apb(1, 8'h24, k << 6); apb(1, 8'h00, p);
      apb(1, 8'h30, k != 1); apb(1, 8'h04, 8'h20 | fs);
      cyc = 0; e1 = 0; e2 = 0;
      while (detect_busy !== 1'b1 && cyc < 4) begin
        @(posedge clk);
        cyc = cyc + 1;
      end
      chk(detect_busy & key_osc_en & ref_osc_en, 1, "run start");
      cyc = 0;
      while (detect_busy === 1'b1) begin
        @(posedge clk);
        cyc = cyc + 1;
        ce <= !(k == 2 && cyc >= 8 && cyc < 48);
        if (cyc % 4 == 0 && e1 < 2 * n1) begin t1 <= ~t1; e1 = e1 + 1; end
        if (cyc % 4 == 2 && e2 < 2 * n2) begin t2 <= ~t2; e2 = e2 + 1; end
      end
      ex = (256 - p) * 128 + (k == 2 ? 40 : 0);
      chk(cyc >= ex - 4 && cyc <= ex + 8, 1, "window length");
      chk(irq, k != 1, "irq level");
      chk(touch_irq_request, 1, "request");
      apb(0, 8'h04, 0); chk(rd, 32'h60 | fs, "control0 after");
      rd16(8'h14); chk(v, cf_q.pop_front(), "cf count");
      rd16(8'h0c); f1 = v;
      ex = (cyc - (k == 2 ? 40 : 0)) >> fs;
      chk(f1 + 3 >= ex && f1 <= ex + 3, 1, "function count");
      rd16(8'h0c); chk(v, f1, "function frozen");
      apb(1, 8'h2c, 1); chk(irq, 0, "irq cleared");
      chk(osc_config, k << 6, "osc config port");
      chk(touch_input_1_en & touch_input_2_en, 1, "key enables");
      apb(0, 8'h28, 0);
      chk(rd, 32'hb3, "module control1");
      apb(1, 8'h04, 0);
      rd16(8'h14); chk(v, 0, "cf cleared");
      rd16(8'h0c); chk(v, 0, "function cleared");
    end
    apb(1, 8'h30, 1); apb(1, 8'h04, 8'hc4);
    apb(0, 8'h04, 0); chk(rd, 32'h40, "control0 set by write");
    chk(touch_irq_request | irq, 0, "no request from write");
    apb(0, 8'h3c, 0); chk(err, 1, "unmapped error");
    // Second reset while idle (start written 0): written registers return to their reset values
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, 8'h04, 0);
    chk(rd, 0, "control0 after reset");
    apb(0, 8'h08, 0);
    chk(rd, 3, "control1 after reset");
    chk(ref_cap_value, 0, "ref cap after reset");
    final_report;
  end
endmodule
bind tkc_top tkc_monitor #(.ADDR_W(ADDR_W)) mon (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .key_osc_en(key_osc_en), .ref_osc_en(ref_osc_en),
  .touch_input_1_en(touch_input_1_en), .touch_input_2_en(touch_input_2_en), .detect_busy(detect_busy), .touch_irq_request(touch_irq_request));
